// [bench/relay_channel_router_tb_top.sv]
// testbench: APB scenarios for the relay channel router
`timescale 1ns/1ps
`default_nettype none
module relay_channel_router_tb_top;
  import relay_router_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic er;} note_type;
  logic           i_core_clk = 1'b0;
  logic           i_reset_n = 1'b0;
  logic           psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0000_0000;
  logic           o_pready, o_pslverr, lamp, fault, junc, ratio, epulse;
  logic [31:0]    o_prdata;
  logic [4:0]     cur_ok, met_ok, rc;
  logic [159:0]   drive, contacts, hold;
  logic [1:0]     msg;
  logic [7:0]     ecode;
  note_type       notes[$];
  int             fail_count = 0;
  int             comparisons = 0;
  int             seed = 27464;

  always #5 i_core_clk = ~i_core_clk;

  relay_channel_router dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_slot_current_ok(cur_ok),
    .i_slot_meter_ok(met_ok), .o_relay_drive(drive), .o_closed_route_lamp(lamp),
    .o_fault_lamp(fault), .o_sim_junction(junc), .o_ratio_avg_off(ratio), .o_message(msg),
    .o_error_code(ecode), .o_error_pulse(epulse));
  slot_module_model partner (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_relay_drive(drive), .o_slot_current_ok(cur_ok), .o_slot_meter_ok(met_ok),
    .o_contact_state(contacts));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] b(input int c);
    return 32'h0000_0001 << c;
  endfunction : b

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge i_core_clk);
    pen <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic cmd(input op_type o, input logic [2:0] s, input logic [4:0] c, input logic r);
    apb(1'b1, CMD_OFF, {15'h0000, r, 1'b0, o, 1'b0, s, 3'h0, c});
  endtask : cmd

  task automatic fn(input func_type f);
    apb(1'b1, FUNC_OFF, {15'h0000, 1'b1, 13'h0000, f});
  endtask : fn

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    notes.push_back('{e, m, er});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic rs(input int s, input logic [31:0] e);
    rd(RELAY_OFF + 12'(4 * (s - 1)), e, 32'hFFFF_FFFF, 1'b0);
  endtask : rs

  task automatic chk(input logic g, input logic e);
    @(negedge i_core_clk);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t port level %b", $time, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk) begin : watch
    note_type n;
    if (psel && pen && o_pready === 1'b1 && !pwr) begin
      n = notes.pop_front();
      comparisons++;
      if ({o_pslverr, o_prdata & n.m} !== {n.er, n.e}) begin
        fail_count++;
        $display("[ERR] %0t read %h at %h", $time, o_prdata, paddr);
      end
    end
  end

  initial begin : watchdog
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rc = 5'($random(seed) & 15) + 5'h01;
    for (int s = 1; s <= 5; s++) rs(s, 32'h0000_0000);
    rd(12'h040, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    cmd(OP_MULTI_CLOSE, 3'h1, 5'h03, 1'b1);
    cmd(OP_MULTI_CLOSE, 3'h2, 5'h19, 1'b1);
    cmd(OP_MULTI_CLOSE, 3'h2, rc, 1'b1);
    chk(lamp, 1'b0);
    rs(1, b(3));
    rs(2, b(25) | b(rc));
    fn(FN_TEMP);
    @(negedge i_core_clk);
    chk(fault, 1'b1);
    chk(junc, 1'b1);
    fn(FN_DC_CURRENT);
    rd(STATUS_OFF, 32'h0000_0000, 32'h0000_FF03, 1'b0);
    cmd(OP_SYS_CLOSE, 3'h1, 5'h05, 1'b1);
    rd(STATUS_OFF, {16'h0000, ERR_RANGE, 8'h01}, 32'h0000_FF03, 1'b0);
    rs(1, b(3));
    fn(FN_DCV);
    cmd(OP_MULTI_OPEN, 3'h2, 5'h19, 1'b1);
    rs(2, b(rc));
    cmd(OP_SYS_CLOSE, 3'h2, 5'h07, 1'b1);
    rs(2, b(rc) | b(7) | b(25));
    rs(1, b(3));
    chk(lamp, 1'b1);
    cmd(OP_OPEN_ALL, 3'h0, 5'h00, 1'b1);
    for (int s = 1; s <= 5; s++) rs(s, 32'h0000_0000);
    rd(STATUS_OFF, 32'h0000_0008, 32'h0000_0008, 1'b0);
    chk(ratio, 1'b1);
    cmd(OP_SYS_CLOSE, 3'h1, 5'h04, 1'b1);
    rs(1, b(4) | b(25));
    fn(FN_DC_CURRENT);
    @(negedge i_core_clk);
    chk(epulse, 1'b1);
    rd(STATUS_OFF, {16'h0000, ERR_SETTINGS, 8'h02}, 32'h0000_FF03, 1'b0);
    chk(ecode === ERR_SETTINGS, 1'b1);
    rd(FUNC_OFF, 32'h0000_0000, 32'h0000_0007, 1'b0);
    rs(1, b(4) | b(25));
    cmd(OP_SYS_CLOSE, 3'h3, 5'h02, 1'b0);
    rd(STATUS_OFF, 32'h0000_0003, 32'h0000_0003, 1'b0);
    rs(3, 32'h0000_0000);
    chk(msg === MSG_NO_METER, 1'b1);
    cmd(OP_MULTI_CLOSE, 3'h3, 5'h01, 1'b1);
    cmd(OP_SYS_CLOSE, 3'h3, 5'h09, 1'b1);
    rs(3, b(9));
    chk(drive[64 +: 32] === b(9), 1'b1);
    cmd(OP_SYS_CLOSE, 3'h6, 5'h01, 1'b1);
    rd(STATUS_OFF, {16'h0000, ERR_RANGE, 8'h00}, 32'h0000_FF00, 1'b0);
    rs(3, b(9));
    hold = drive;
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk(contacts === hold, 1'b1);
    chk(drive === '0, 1'b1);
    @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rd(STATUS_OFF, 32'h0000_0000, 32'h0000_FF0F, 1'b0);
    rd(FUNC_OFF, 32'h0000_0000, 32'h0000_0007, 1'b0);
    give_verdict();
  end
endmodule : relay_channel_router_tb_top
`default_nettype wire

// [bench/relay_router_assertions.sv]
// checker: port-level properties of the relay channel router
`timescale 1ns/1ps
`default_nettype none
module relay_router_assertions
  import relay_router_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_reset_n,
  input wire logic         i_psel,
  input wire logic         i_penable,
  input wire logic         i_pwrite,
  input wire logic [11:0]  i_paddr,
  input wire logic [31:0]  i_pwdata,
  input wire logic         o_pready,
  input wire logic         o_pslverr,
  input wire logic [159:0] o_relay_drive,
  input wire logic         o_closed_route_lamp,
  input wire logic         o_fault_lamp,
  input wire logic         o_sim_junction,
  input wire logic         o_ratio_avg_off,
  input wire logic [1:0]   o_message,
  input wire logic [7:0]   o_error_code,
  input wire logic         o_error_pulse
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence cmd_take(logic [2:0] code);
    i_psel && i_penable && i_pwrite && i_paddr == CMD_OFF && i_pwdata[14:12] == code;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (o_pready) else $error("pready low");
  a_slverr_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  a_pulse_single: assert property (o_error_pulse |=> !o_error_pulse)
    else $error("error pulse too long");
  a_pulse_code: assert property (o_error_pulse |->
    (o_error_code == ERR_RANGE || o_error_code == ERR_SETTINGS)) else $error("bad error code");
  a_open_clears: assert property (cmd_take(3'h4) |=>
    o_relay_drive == '0 && o_ratio_avg_off) else $error("open-all incomplete");
  a_multi_keeps: assert property (cmd_take(3'h2) |=>
    (o_relay_drive & $past(o_relay_drive)) == $past(o_relay_drive)) else $error("closure lost");
  a_multi_lamp: assert property (cmd_take(3'h2) |=> $stable(o_closed_route_lamp))
    else $error("lamp changed by multi close");
  a_multi_open: assert property (cmd_take(3'h3) |=>
    (o_relay_drive | $past(o_relay_drive)) == $past(o_relay_drive)) else $error("relay closed");
  a_msg_hold: assert property ($changed(o_message) && o_message != MSG_NONE |->
    (o_message != MSG_NONE) [*8]) else $error("message too short");
  a_fault_pair: assert property (o_fault_lamp == o_sim_junction
    && (!o_fault_lamp || |o_relay_drive)) else $error("fault lamp and junction differ");
endmodule : relay_router_assertions

bind relay_channel_router relay_router_assertions chk (.*);
`default_nettype wire

// [bench/slot_module_model.sv]
// partner: plug-in module straps and latching relay contacts
`timescale 1ns/1ps
`default_nettype none
module slot_module_model #(
  parameter logic [4:0] CURRENT_OK = 5'h1E,
  parameter logic [4:0] METER_OK   = 5'h1B
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  input  wire logic [159:0] i_relay_drive,
  output logic [4:0]        o_slot_current_ok,
  output logic [4:0]        o_slot_meter_ok,
  output logic [159:0]      o_contact_state
);
  assign o_slot_current_ok = CURRENT_OK;
  assign o_slot_meter_ok   = METER_OK;
  // contacts latch: drive loss in reset leaves them as they were
  always_ff @(posedge i_core_clk) begin
    if (i_reset_n) begin
      o_contact_state <= i_relay_drive;
    end
  end
endmodule : slot_module_model
`default_nettype wire

// [rtl/relay_apb_slave.sv]
// APB slave: command decode and register readback
`timescale 1ns/1ps
`default_nettype none
module relay_apb_slave
  import relay_router_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [31:0] i_rd_word,
  output logic             o_rd_hit,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  relay_cmd_if.src         cmd
);
  logic        access;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  assign access   = i_psel && i_penable;
  assign o_pready = 1'b1;

  always_comb begin
    cmd.valid      = 1'b0;
    cmd.op         = OP_NONE;
    cmd.slot       = i_pwdata[SLOT_LSB +: SLOT_W];
    cmd.closed_route_lamp       = i_pwdata[CLOSED_ROUTE_LAMP_LSB +: CLOSED_ROUTE_LAMP_W];
    cmd.remote     = i_pwdata[REMOTE_BIT];
    cmd.func_valid = 1'b0;
    cmd.func       = i_pwdata[FUNC_LSB +: FUNC_W];
    o_pslverr      = 1'b0;
    o_rd_hit       = 1'b0;
    if (access && i_pwrite) begin
      if (i_paddr == CMD_OFF) begin
        cmd.valid = 1'b1;
        cmd.op    = op_type'(i_pwdata[OP_LSB +: OP_W]);
      end else if (i_paddr == FUNC_OFF) begin
        cmd.func_valid = 1'b1;
      end else begin
        o_pslverr = 1'b1;
      end
    end else if (access) begin
      o_rd_hit = 1'b1;
      o_pslverr = (i_paddr[11:2] > RELAY_OFF[11:2] + 10'(NUM_SLOTS) - 10'h001);
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (i_psel && !i_penable && !i_pwrite) begin
      rdata_next = i_rd_word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_prdata = rdata_reg;
endmodule : relay_apb_slave
`default_nettype wire

// [rtl/relay_channel_router.sv]
// top: relay channel router with APB register access
// Notes on behaviour
// - current function on: system close to non-current module refused, message, error -222
// - current function refused if system channel closed on non-current module; error -221
// - channel closed by multi close still permits current function selection
// - remote system close on non-meter module closes only that channel
// - front-panel system close on non-meter module refused with message
// - non-meter module channels never routed to internal meter
// - multi close keeps all earlier closed channels
// - multi close never changes displayed channel or closed-route lamp
// - multi open opens only the named channel
// - multi operation may close several channels and isolation relays
// - thermocouple on multi-set channels uses simulated junction, fault lamp on
// - two-wire system close also closes isolation relay, keeps multi closures
// - relay states are latching and held through power off
// - channel entry is slot 1..5 then two-digit channel number
// - open-all opens every channel and disables ratio and averaging
`timescale 1ns/1ps
`default_nettype none
module relay_channel_router
  import relay_router_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  input  wire logic [4:0]  i_slot_current_ok,
  input  wire logic [4:0]  i_slot_meter_ok,
  output logic [159:0]     o_relay_drive,
  output logic             o_closed_route_lamp,
  output logic             o_fault_lamp,
  output logic             o_sim_junction,
  output logic             o_ratio_avg_off,
  output logic [1:0]       o_message,
  output logic [7:0]       o_error_code,
  output logic             o_error_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  relay_cmd_if cmd ();

  logic [4:0] cur_s1;
  logic [4:0] cur_s2;
  logic [4:0] mtr_s1;
  logic [4:0] mtr_s2;

  logic [NUM_CHANS-1:0] relay_reg  [NUM_SLOTS];
  logic [NUM_CHANS-1:0] relay_next [NUM_SLOTS];
  logic [NUM_CHANS-1:0] multi_reg  [NUM_SLOTS];
  logic [NUM_CHANS-1:0] multi_next [NUM_SLOTS];
  logic [2:0]  func_reg, func_next;
  logic        sys_valid_reg, sys_valid_next;
  logic [2:0]  sys_slot_reg, sys_slot_next;
  logic [4:0]  sys_closed_route_lamp_reg, sys_closed_route_lamp_next;
  logic        lamp_reg, lamp_next;
  logic        ratio_off_reg, ratio_off_next;
  logic [7:0]  err_reg, err_next;
  logic        err_pulse_reg, err_pulse_next;
  logic        msg_start;
  msg_type     msg_sel;
  msg_type     msg_out;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] sysch_word;
  logic [31:0] cap_word;
  logic        slot_ok;
  logic [2:0]  sidx;
  logic        any_multi;

  ////////////////////////////////////////////////////////////////////////////
  // slot number to array index
  function automatic logic [SLOT_W-1:0] slot_index(input logic [SLOT_W-1:0] slot);
    return slot - SLOT_W'(1);
  endfunction : slot_index

  // slot number within the populated range
  function automatic logic slot_in_range(input logic [SLOT_W-1:0] slot);
    return (slot >= SLOT_W'(1)) && (slot <= SLOT_W'(NUM_SLOTS));
  endfunction : slot_in_range

  // isolation relay joins the route for two-wire functions
  function automatic logic is_two_wire(input logic [2:0] f);
    return f != FN_OHM4;
  endfunction : is_two_wire

  // word address to relay bank index
  function automatic logic [SLOT_W-1:0] relay_bank(input logic [11:0] addr);
    return SLOT_W'(addr[11:2] - RELAY_OFF[11:2]);
  endfunction : relay_bank

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for module capability straps
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_s1 <= 5'h00;
      cur_s2 <= 5'h00;
      mtr_s1 <= 5'h00;
      mtr_s2 <= 5'h00;
    end else begin
      cur_s1 <= i_slot_current_ok;
      cur_s2 <= cur_s1;
      mtr_s1 <= i_slot_meter_ok;
      mtr_s2 <= mtr_s1;
    end
  end

  relay_apb_slave u_apb (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_psel     (i_psel),
    .i_penable  (i_penable),
    .i_pwrite   (i_pwrite),
    .i_paddr    (i_paddr),
    .i_pwdata   (i_pwdata),
    .i_rd_word  (rd_word),
    .o_rd_hit   (),
    .o_pready   (o_pready),
    .o_pslverr  (o_pslverr),
    .o_prdata   (o_prdata),
    .cmd        (cmd)
  );

  relay_msg_timer u_msg (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (msg_start),
    .i_msg      (msg_sel),
    .o_msg      (msg_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command execution
  assign slot_ok = slot_in_range(cmd.slot);
  assign sidx    = slot_ok ? slot_index(cmd.slot) : '0;

  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      relay_next[s] = relay_reg[s];
      multi_next[s] = multi_reg[s];
    end
    func_next      = func_reg;
    sys_valid_next = sys_valid_reg;
    sys_slot_next  = sys_slot_reg;
    sys_closed_route_lamp_next  = sys_closed_route_lamp_reg;
    lamp_next      = lamp_reg;
    ratio_off_next = ratio_off_reg;
    err_next       = err_reg;
    err_pulse_next = 1'b0;
    msg_start      = 1'b0;
    msg_sel        = MSG_NONE;
    if (cmd.func_valid) begin
      if (is_current(cmd.func) && sys_valid_reg
          && !cur_s2[slot_index(sys_slot_reg)]) begin
        msg_start = 1'b1;
        msg_sel   = MSG_BAD_FUNC;
        if (cmd.remote) begin
          err_next       = ERR_SETTINGS;
          err_pulse_next = 1'b1;
        end
      end else begin
        func_next = cmd.func;
      end
    end else if (cmd.valid) begin
      unique case (cmd.op)
        OP_SYS_CLOSE: begin
          if (!slot_ok) begin
            if (cmd.remote) begin
              err_next       = ERR_RANGE;
              err_pulse_next = 1'b1;
            end
          end else if (!mtr_s2[sidx] && !cmd.remote) begin
            msg_start = 1'b1;
            msg_sel   = MSG_NO_METER;
          end else if (!mtr_s2[sidx]) begin
            relay_next[sidx] = '0;
            relay_next[sidx][cmd.closed_route_lamp] = 1'b1;
            multi_next[sidx] = '0;
          end else if (is_current(func_reg) && !cur_s2[sidx]) begin
            msg_start = 1'b1;
            msg_sel   = MSG_NO_CURRENT;
            if (cmd.remote) begin
              err_next       = ERR_RANGE;
              err_pulse_next = 1'b1;
            end
          end else begin
            if (sys_valid_reg) begin
              relay_next[slot_index(sys_slot_reg)][sys_closed_route_lamp_reg] = 1'b0;
            end
            relay_next[sidx][cmd.closed_route_lamp] = 1'b1;
            if (is_two_wire(func_reg)) begin
              relay_next[sidx][ISO_CLOSED_ROUTE_LAMP] = 1'b1;
            end
            multi_next[sidx][cmd.closed_route_lamp] = 1'b0;
            sys_valid_next = 1'b1;
            sys_slot_next  = cmd.slot;
            sys_closed_route_lamp_next  = cmd.closed_route_lamp;
            lamp_next      = 1'b1;
            ratio_off_next = 1'b0;
          end
        end
        OP_MULTI_CLOSE: begin
          if (slot_ok) begin
            relay_next[sidx][cmd.closed_route_lamp] = 1'b1;
            multi_next[sidx][cmd.closed_route_lamp] = 1'b1;
          end
        end
        OP_MULTI_OPEN: begin
          if (slot_ok) begin
            relay_next[sidx][cmd.closed_route_lamp] = 1'b0;
            multi_next[sidx][cmd.closed_route_lamp] = 1'b0;
          end
        end
        OP_OPEN_ALL: begin
          for (int s = 0; s < NUM_SLOTS; s++) begin
            relay_next[s] = '0;
            multi_next[s] = '0;
          end
          sys_valid_next = 1'b0;
          lamp_next      = 1'b0;
          ratio_off_next = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers; cleared whenever i_reset_n is low (sys_slot_reg loads slot 1), relays latch
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        relay_reg[s] <= '0;
        multi_reg[s] <= '0;
      end
      func_reg      <= FN_DCV;
      sys_valid_reg <= 1'b0;
      sys_slot_reg  <= 3'h1;
      sys_closed_route_lamp_reg  <= 5'h00;
      lamp_reg      <= 1'b0;
      ratio_off_reg <= 1'b0;
      err_reg       <= 8'h00;
      err_pulse_reg <= 1'b0;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        relay_reg[s] <= relay_next[s];
        multi_reg[s] <= multi_next[s];
      end
      func_reg      <= func_next;
      sys_valid_reg <= sys_valid_next;
      sys_slot_reg  <= sys_slot_next;
      sys_closed_route_lamp_reg  <= sys_closed_route_lamp_next;
      lamp_reg      <= lamp_next;
      ratio_off_reg <= ratio_off_next;
      err_reg       <= err_next;
      err_pulse_reg <= err_pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback mux
  always_comb begin
    rd_word = ZERO_WORD;
    if (i_paddr == FUNC_OFF) begin
      rd_word = {29'h0, func_reg};
    end else if (i_paddr == STATUS_OFF) begin
      rd_word = status_word;
    end else if (i_paddr == SYSCH_OFF) begin
      rd_word = sysch_word;
    end else if (i_paddr == CAP_OFF) begin
      rd_word = cap_word;
    end else if (i_paddr[11:2] >= RELAY_OFF[11:2]
                 && i_paddr[11:2] < RELAY_OFF[11:2] + 10'(NUM_SLOTS)) begin
      rd_word = relay_reg[relay_bank(i_paddr)];
    end
  end

  assign status_word = {16'h0, err_reg, 4'h0, ratio_off_reg, o_fault_lamp, msg_out};
  assign sysch_word  = {23'h0, sys_valid_reg, sys_slot_reg, sys_closed_route_lamp_reg};
  assign cap_word    = {19'h0, mtr_s2, 3'h0, cur_s2};

  always_comb begin
    any_multi = 1'b0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      any_multi = any_multi | (|multi_reg[s]);
    end
  end

  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_drive
    assign o_relay_drive[s*NUM_CHANS +: NUM_CHANS] = relay_reg[s];
  end

  assign o_sim_junction      = (func_reg == FN_TEMP) && any_multi;
  assign o_fault_lamp        = o_sim_junction;
  assign o_closed_route_lamp = lamp_reg;
  assign o_ratio_avg_off     = ratio_off_reg;
  assign o_message           = msg_out;
  assign o_error_code        = err_reg;
  assign o_error_pulse       = err_pulse_reg;

endmodule : relay_channel_router
`default_nettype wire

// [rtl/relay_cmd_if.sv]
// interface: decoded command from bus slave to router core
`timescale 1ns/1ps
`default_nettype none
interface relay_cmd_if;
  import relay_router_pkg::*;
  logic              valid;
  op_type            op;
  logic [SLOT_W-1:0] slot;
  logic [CLOSED_ROUTE_LAMP_W-1:0] closed_route_lamp;
  logic              remote;
  logic              func_valid;
  logic [2:0]        func;
  modport src (output valid, op, slot, closed_route_lamp, remote, func_valid, func);
  modport dst (input  valid, op, slot, closed_route_lamp, remote, func_valid, func);
endinterface : relay_cmd_if
`default_nettype wire

// [rtl/relay_msg_timer.sv]
// brief front-panel message hold timer
`timescale 1ns/1ps
`default_nettype none
module relay_msg_timer
  import relay_router_pkg::*;
#(
  parameter int CYCLES = MSG_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_start,
  input  wire msg_type i_msg,
  output msg_type   o_msg
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  msg_type     msg_reg;
  msg_type     msg_next;

  always_comb begin
    cnt_next = cnt_reg;
    msg_next = msg_reg;
    if (i_start) begin
      cnt_next = 16'(CYCLES);
      msg_next = i_msg;
    end else if (cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
      if (cnt_reg == 16'h0001) begin
        msg_next = MSG_NONE;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 16'h0000;
      msg_reg <= MSG_NONE;
    end else begin
      cnt_reg <= cnt_next;
      msg_reg <= msg_next;
    end
  end

  assign o_msg = msg_reg;
endmodule : relay_msg_timer
`default_nettype wire

// [rtl/relay_router_pkg.sv]
// package: constants, register map and types for the relay channel router
package relay_router_pkg;

  localparam int NUM_SLOTS   = 5;
  localparam int NUM_CHANS   = 32;
  localparam int SLOT_W      = 3;
  localparam int CLOSED_ROUTE_LAMP_W      = 5;
  localparam int ISO_CLOSED_ROUTE_LAMP    = 25;
  localparam int CLOSED_ROUTE_LAMP_LSB    = 0;
  localparam int SLOT_LSB    = 8;
  localparam int OP_LSB      = 12;
  localparam int OP_W        = 3;
  localparam int REMOTE_BIT  = 16;
  localparam int FUNC_LSB    = 0;
  localparam int FUNC_W      = 3;
  localparam int MSG_TIME_NS = 2000;
  localparam int CLK_NS      = 10;
  localparam int MSG_CYCLES  = (MSG_TIME_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] ERR_SETTINGS = 8'hDD;
  localparam logic [7:0] ERR_RANGE    = 8'hDE;

  localparam logic [11:0] CMD_OFF     = 12'h000;
  localparam logic [11:0] FUNC_OFF    = 12'h004;
  localparam logic [11:0] STATUS_OFF  = 12'h008;
  localparam logic [11:0] SYSCH_OFF   = 12'h00C;
  localparam logic [11:0] CAP_OFF     = 12'h010;
  localparam logic [11:0] RELAY_OFF   = 12'h020;

  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE, OP_SYS_CLOSE, OP_MULTI_CLOSE, OP_MULTI_OPEN, OP_OPEN_ALL
  } op_type;

  typedef enum logic [2:0] {
    FN_DCV, FN_ACV, FN_OHM2, FN_OHM4, FN_DC_CURRENT, FN_AC_CURRENT, FN_TEMP
  } func_type;

  typedef enum logic [1:0] {
    MSG_NONE, MSG_NO_CURRENT, MSG_BAD_FUNC, MSG_NO_METER
  } msg_type;

  function automatic logic is_current(input logic [2:0] f);
    return (f == FN_DC_CURRENT) || (f == FN_AC_CURRENT);
  endfunction : is_current

endpackage : relay_router_pkg
